// ==== core/lmic_pkg.sv ====
// lmic_pkg: register codes, field positions, timing and carrier types for
// the led matrix intensity and plane control block.
// assumes a 125 MHz core clock and a decoded serial register write port.
package lmic_pkg;

   // -------------------------------------------------------------------
   // register codes
   // -------------------------------------------------------------------
   localparam logic [7:0] ADDR_PANEL   = 8'h02;
   localparam logic [7:0] ADDR_DIG0    = 8'h03;
   localparam logic [7:0] ADDR_DIG1    = 8'h04;
   localparam logic [7:0] ADDR_DRV     = 8'h08;
   localparam logic [7:0] ADDR_DPTR_LO = 8'h09;
   localparam logic [7:0] ADDR_DPTR_HI = 8'h0A;
   localparam logic [7:0] ADDR_PLANE   = 8'h0B;
   localparam logic [7:0] ADDR_CFG     = 8'h0D;

   // -------------------------------------------------------------------
   // fields
   // -------------------------------------------------------------------
   localparam int         CFG_DEPTH_BIT = 7;
   localparam int         CFG_PLANE_LSB = 2;
   localparam int         PC_FAST_BIT   = 7;
   localparam int         PC_AUTO_BIT   = 6;
   localparam int         PC_CNT_W      = 6;
   localparam int         DPTR_W        = 14;
   localparam int         DPTR_HI_W     = 6;
   localparam logic [7:0] PANEL_MIN     = 8'h02;
   localparam logic [7:0] PANEL_LOW_MAX = 8'h02;
   localparam logic [1:0] PLANE_FIRST   = 2'h0;
   localparam logic [3:0] PAT_LEN       = 4'hC;
   localparam logic [1:0] PIX_FULL      = 2'h3;
   localparam logic [1:0] PIX_HIGH      = 2'h2;
   localparam logic [1:0] PIX_LOW       = 2'h1;

   // -------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 8;
   localparam int SECOND_NS       = 1000000000;
   localparam int SEC_CYC         = SECOND_NS / CLK_PERIOD_NS;
   localparam int DIGIT_PERIOD_NS = 122000;
   localparam int PWM_STEPS       = 256;
   // longest step time, so rounded down
   localparam int PWM_STEP_CYC    =
      DIGIT_PERIOD_NS / (CLK_PERIOD_NS * PWM_STEPS);

   // -------------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------------
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } lmic_reg_req_t;

   typedef struct packed {
      logic       panel_on;
      logic [1:0] digit_on;
      logic [1:0] pixel_on;
   } lmic_drive_t;

   typedef struct packed {
      logic [7:0]        panel;
      logic [1:0][7:0]   dig_int;
      logic [7:0]        drv_sel;
      logic [13:0]       dptr;
      logic [7:0]        pc;
      logic              pc_pend;
      logic [7:0]        cfg;
      logic [1:0]        plane;
      logic [31:0]       acc;
      logic [5:0]        sec_cnt;
      logic [15:0]       step_cnt;
      logic [7:0]        pwm_cnt;
      logic [3:0]        frame_idx;
      logic [7:0]        rdata;
      lmic_drive_t       drive;
   } lmic_state_t;

   localparam lmic_state_t STATE_RST = '0;

endpackage : lmic_pkg

// ==== core/lmic_digit.sv ====
// lmic_digit: per-digit duty scaling and pixel frame modulation.
// purely combinational; the caller registers every result.
`timescale 1ns/100ps
`default_nettype none

module lmic_digit
(
   input  wire logic [7:0] panel_duty,
   input  wire logic [7:0] dig_int,
   input  wire logic [7:0] pwm_cnt,
   input  wire logic [3:0] frame_idx,
   input  wire logic [1:0] pix_code,
   input  wire logic       two_bit,
   input  wire logic       geometric,
   output logic            digit_on,
   output logic            pixel_on
);

   logic [15:0] prod;
   logic [7:0]  duty;
   logic [1:0]  mod3;
   logic [1:0]  mod4;

   always_comb
   begin
      prod     = 16'(panel_duty) * 16'(dig_int);
      duty     = prod[15:8];
      digit_on = pwm_cnt < duty;
      mod3     = 2'(frame_idx % 4'h3);
      mod4     = frame_idx[1:0];
      // ------------------------------------------------------------
      // pixel level: pix_code bit 0 in one-bit depth, else from the 12-frame pattern
      // ------------------------------------------------------------
      if (!two_bit)
      begin
         pixel_on = pix_code[0];
      end
      else
      begin
         case (pix_code)
            lmic_pkg::PIX_FULL: pixel_on = 1'b1;
            lmic_pkg::PIX_HIGH:
               pixel_on = geometric ? ~frame_idx[0] : (mod3 != 2'h1);
            lmic_pkg::PIX_LOW:
               pixel_on = geometric ? (mod4 == 2'h1) : (mod3 == 2'h1);
            default: pixel_on = 1'b0;
         endcase
      end
   end

endmodule : lmic_digit
`default_nettype wire

// ==== core/lmic_top.sv ====
// lmic_top: panel brightness, digit intensity, plane depth, indirect
// pointers and plane sequencer of one matrix driver.
// assumes the serial front end hands over decoded register writes, a
// pulse per data byte and a pulse at the chip-select rising edge, all
// synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none

module lmic_top
#(
   parameter bit FOUR_STEP    = 1'b1,
   parameter int SEC_CYC      = lmic_pkg::SEC_CYC,
   parameter int PWM_STEP_CYC = lmic_pkg::PWM_STEP_CYC
)
(
   input  wire logic                  core_clk,
   input  wire logic                  resetn,
   input  wire lmic_pkg::lmic_reg_req_t req,
   input  wire logic [7:0]            rd_addr,
   input  wire logic                  byte_done,
   input  wire logic                  cs_rise,
   input  wire logic [1:0]            digit_geometric,
   input  wire logic [1:0][1:0]       pix_code,
   output lmic_pkg::lmic_drive_t      drive,
   output logic [7:0]                 rdata,
   output logic [1:0]                 cur_plane,
   output logic                       plane_depth_select,
   output logic [13:0]                disp_ptr,
   output logic [7:0]                 driver_sel
);

   lmic_pkg::lmic_state_t s_q;
   lmic_pkg::lmic_state_t s_d;
   logic [7:0]            panel_duty;
   logic [1:0]            dig_on;
   logic [1:0]            pix_on;
   logic                  two_bit;
   logic [5:0]            cnt_n;
   logic                  auto_on;
   logic                  fast_on;
   logic                  advance;
   logic [31:0]           acc_sum;
   logic [1:0]            last_plane;

   // --------------------------------------------------------------------
   // per-digit scaling
   // --------------------------------------------------------------------
   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_digit
         lmic_digit u_digit
         (
            .panel_duty (panel_duty),
            .dig_int    (s_q.dig_int[g]),
            .pwm_cnt    (s_q.pwm_cnt),
            .frame_idx  (s_q.frame_idx),
            .pix_code   (pix_code[g]),
            .two_bit    (two_bit),
            .geometric  (digit_geometric[g]),
            .digit_on   (dig_on[g]),
            .pixel_on   (pix_on[g])
         );
      end
   endgenerate

   // --------------------------------------------------------------------
   // next state
   // --------------------------------------------------------------------
   always_comb
   begin
      s_d     = s_q;
      two_bit = s_q.cfg[lmic_pkg::CFG_DEPTH_BIT];
      // codes below the minimum clamp to 2/256
      panel_duty = (s_q.panel <= lmic_pkg::PANEL_LOW_MAX)
                 ? lmic_pkg::PANEL_MIN : s_q.panel;
      cnt_n      = s_q.pc[lmic_pkg::PC_CNT_W-1:0];
      // an uncommitted plane register must not start or steer the timer
      auto_on    = s_q.pc[lmic_pkg::PC_AUTO_BIT] && !s_q.pc_pend;
      fast_on    = s_q.pc[lmic_pkg::PC_FAST_BIT];
      last_plane = two_bit ? 2'h1 : 2'h3;
      advance    = 1'b0;
      acc_sum    = 32'h00000000;

      // PWM step prescaler and 12-frame modulation index
      if (s_q.step_cnt >= 16'(PWM_STEP_CYC - 1))
      begin
         s_d.step_cnt = 16'h0000;
         s_d.pwm_cnt  = s_q.pwm_cnt + 8'h01;
         if (s_q.pwm_cnt == 8'hFF)
         begin
            s_d.frame_idx = (s_q.frame_idx >= lmic_pkg::PAT_LEN - 4'h1)
                          ? 4'h0 : s_q.frame_idx + 4'h1;
         end
      end
      else
      begin
         s_d.step_cnt = s_q.step_cnt + 16'h0001;
      end

      // ---------------------------------------------------------------
      // automatic plane timer
      // ---------------------------------------------------------------
      if (auto_on && cnt_n != 6'h00)
      begin
         if (fast_on)
         begin
            // adds N per cycle, so N wraps per second
            acc_sum = s_q.acc + 32'(cnt_n);
            if (acc_sum >= 32'(SEC_CYC))
            begin
               s_d.acc = acc_sum - 32'(SEC_CYC);
               advance = 1'b1;
            end
            else
            begin
               s_d.acc = acc_sum;
            end
         end
         else
         begin
            if (s_q.acc >= 32'(SEC_CYC - 1))
            begin
               s_d.acc = 32'h00000000;
               if (s_q.sec_cnt + 6'h01 >= cnt_n)
               begin
                  s_d.sec_cnt = 6'h00;
                  advance     = 1'b1;
               end
               else
               begin
                  s_d.sec_cnt = s_q.sec_cnt + 6'h01;
               end
            end
            else
            begin
               s_d.acc = s_q.acc + 32'h00000001;
            end
         end
      end

      if (advance)
      begin
         s_d.plane = (s_q.plane >= last_plane)
                   ? lmic_pkg::PLANE_FIRST : s_q.plane + 2'h1;
      end
      else if (two_bit && s_q.plane > last_plane)
      begin
         s_d.plane = {1'b0, s_q.plane[0]};
      end

      // display pointer steps per data byte; a pointer register write wins for the bits it writes
      if (byte_done)
      begin
         s_d.dptr = s_q.dptr + 14'h0001;
      end

      // ---------------------------------------------------------------
      // register writes
      // ---------------------------------------------------------------
      if (req.wr)
      begin
         case (req.addr)
            lmic_pkg::ADDR_PANEL: s_d.panel      = req.data;
            lmic_pkg::ADDR_DIG0:  s_d.dig_int[0] = req.data;
            lmic_pkg::ADDR_DIG1:  s_d.dig_int[1] = req.data;
            lmic_pkg::ADDR_DRV:   s_d.drv_sel    = req.data;
            lmic_pkg::ADDR_DPTR_LO:
               s_d.dptr[7:0] = req.data;
            lmic_pkg::ADDR_DPTR_HI:
               s_d.dptr[lmic_pkg::DPTR_W-1:8] =
                  req.data[lmic_pkg::DPTR_HI_W-1:0];
            lmic_pkg::ADDR_PLANE:
            begin
               s_d.pc      = req.data;
               s_d.pc_pend = 1'b1;
            end
            lmic_pkg::ADDR_CFG:
            begin
               s_d.cfg = req.data;
               // plane bits are read-only, always show the live plane
               s_d.cfg[lmic_pkg::CFG_PLANE_LSB +: 2] = 2'h0;
               if (!FOUR_STEP)
               begin
                  s_d.cfg[lmic_pkg::CFG_DEPTH_BIT] = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // plane register takes effect at the chip-select rising edge
      if (cs_rise && (s_q.pc_pend || (req.wr
          && req.addr == lmic_pkg::ADDR_PLANE)))
      begin
         s_d.pc_pend = 1'b0;
         s_d.acc     = 32'h00000000;
         s_d.sec_cnt = 6'h00;
         if (s_d.pc[lmic_pkg::PC_AUTO_BIT])
         begin
            s_d.plane = lmic_pkg::PLANE_FIRST;
         end
         else if (s_d.cfg[lmic_pkg::CFG_DEPTH_BIT])
         begin
            s_d.plane = {1'b0, s_d.pc[0]};
         end
         else
         begin
            s_d.plane = s_d.pc[1:0];
         end
      end

      // ---------------------------------------------------------------
      // read back and drive
      // ---------------------------------------------------------------
      case (rd_addr)
         lmic_pkg::ADDR_PANEL:   s_d.rdata = s_q.panel;
         lmic_pkg::ADDR_DIG0:    s_d.rdata = s_q.dig_int[0];
         lmic_pkg::ADDR_DIG1:    s_d.rdata = s_q.dig_int[1];
         lmic_pkg::ADDR_DRV:     s_d.rdata = s_q.drv_sel;
         lmic_pkg::ADDR_DPTR_LO: s_d.rdata = s_q.dptr[7:0];
         lmic_pkg::ADDR_DPTR_HI:
            s_d.rdata = {2'h0, s_q.dptr[lmic_pkg::DPTR_W-1:8]};
         lmic_pkg::ADDR_PLANE:   s_d.rdata = s_q.pc;
         lmic_pkg::ADDR_CFG:
         begin
            s_d.rdata = s_q.cfg;
            s_d.rdata[lmic_pkg::CFG_PLANE_LSB +: 2] = s_q.plane;
         end
         default:                s_d.rdata = 8'h00;
      endcase

      s_d.drive.panel_on = s_q.pwm_cnt < panel_duty;
      s_d.drive.digit_on = dig_on;
      s_d.drive.pixel_on = pix_on;
   end

   // --------------------------------------------------------------------
   // state register
   // --------------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         s_q <= lmic_pkg::STATE_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign drive              = s_q.drive;
   assign rdata              = s_q.rdata;
   assign cur_plane          = s_q.plane;
   assign plane_depth_select = s_q.cfg[lmic_pkg::CFG_DEPTH_BIT];
   assign disp_ptr           = s_q.dptr;
   assign driver_sel         = s_q.drv_sel;

endmodule : lmic_top
`default_nettype wire

// ==== tb/lmic_top_asserts.sv ====
// lmic_top_asserts: port-level checks of lmic_top.
// assumes single clock core_clk and synchronous active-low resetn.
`timescale 1ns/100ps
`default_nettype none

module lmic_top_asserts
#(
   parameter bit FOUR_STEP    = 1'b1,
   parameter int SEC_CYC      = 100,
   parameter int PWM_STEP_CYC = 1
)
(
   input wire logic                    core_clk,
   input wire logic                    resetn,
   input wire lmic_pkg::lmic_reg_req_t req,
   input wire logic [7:0]              rd_addr,
   input wire logic                    byte_done,
   input wire logic                    cs_rise,
   input wire logic [1:0]              digit_geometric,
   input wire logic [1:0][1:0]         pix_code,
   input wire lmic_pkg::lmic_drive_t   drive,
   input wire logic [7:0]              rdata,
   input wire logic [1:0]              cur_plane,
   input wire logic                    plane_depth_select,
   input wire logic [13:0]             disp_ptr,
   input wire logic [7:0]              driver_sel
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   logic wr_ptr;
   assign wr_ptr = req.wr && (req.addr == lmic_pkg::ADDR_DPTR_LO ||
                              req.addr == lmic_pkg::ADDR_DPTR_HI);

   AST_RST: assert property (disable iff (1'b0) !resetn |=> disp_ptr == '0
      && driver_sel == '0 && cur_plane == '0 && rdata == '0)
      else $error("state not cleared by reset");
   AST_DPTR_INC: assert property (byte_done && !wr_ptr |=>
      disp_ptr == $past(disp_ptr) + 14'h0001)
      else $error("display pointer did not step");
   AST_DPTR_LO: assert property (req.wr && !byte_done &&
      req.addr == lmic_pkg::ADDR_DPTR_LO |=> disp_ptr[7:0] == $past(req.data))
      else $error("pointer low byte wrong");
   AST_DPTR_HI: assert property (req.wr && !byte_done &&
      req.addr == lmic_pkg::ADDR_DPTR_HI
      |=> disp_ptr[13:8] == $past(req.data[5:0]))
      else $error("pointer high bits wrong");
   AST_DRV_WR: assert property (req.wr &&
      req.addr == lmic_pkg::ADDR_DRV |=> driver_sel == $past(req.data))
      else $error("driver select wrong");
   AST_RD_PANEL: assert property (req.wr &&
      req.addr == lmic_pkg::ADDR_PANEL && rd_addr == lmic_pkg::ADDR_PANEL
      ##1 rd_addr == lmic_pkg::ADDR_PANEL [*2] |=> rdata == $past(req.data, 3))
      else $error("panel readback wrong");
   AST_DEPTH: assert property (req.wr &&
      req.addr == lmic_pkg::ADDR_CFG
      |=> plane_depth_select == (FOUR_STEP && $past(req.data[7])))
      else $error("plane depth select wrong");
   AST_MANUAL: assert property (req.wr && cs_rise && !req.data[6] &&
      req.addr == lmic_pkg::ADDR_PLANE && !plane_depth_select
      |=> cur_plane == $past(req.data[1:0]))
      else $error("manual plane wrong");
   AST_AUTO_START: assert property (req.wr && cs_rise && req.data[6] &&
      req.addr == lmic_pkg::ADDR_PLANE |=> cur_plane == 2'h0)
      else $error("auto did not start at plane 0");
   AST_ZERO_HOLD: assert property (req.wr && cs_rise &&
      req.addr == lmic_pkg::ADDR_PLANE && req.data == 8'hC0
      |=> cur_plane == 2'h0 [*8])
      else $error("zero count did not hold");

   cover property (byte_done && disp_ptr == 14'h3FFF);
   cover property (req.wr && cs_rise);
   cover property ($rose(plane_depth_select));
endmodule : lmic_top_asserts

bind lmic_top lmic_top_asserts #(.FOUR_STEP(FOUR_STEP), .SEC_CYC(SEC_CYC),
   .PWM_STEP_CYC(PWM_STEP_CYC)) u_chk (.core_clk(core_clk),
   .resetn(resetn), .req(req), .rd_addr(rd_addr), .byte_done(byte_done),
   .cs_rise(cs_rise), .digit_geometric(digit_geometric),
   .pix_code(pix_code), .drive(drive), .rdata(rdata),
   .cur_plane(cur_plane), .plane_depth_select(plane_depth_select),
   .disp_ptr(disp_ptr), .driver_sel(driver_sel));

`default_nettype wire

// ==== tb/lmic_host.sv ====
// lmic_host: host side of the decoded register port.
// assumes all its outputs may change at the falling edge of core_clk.
`timescale 1ns/100ps
`default_nettype none

module lmic_host
(
   input  wire logic               core_clk,
   input  wire logic [7:0]         rdata,
   output lmic_pkg::lmic_reg_req_t req,
   output logic [7:0]              rd_addr,
   output logic                    byte_done,
   output logic                    cs_rise
);
   initial
   begin
      req       = '0;
      rd_addr   = 8'h00;
      byte_done = 1'b0;
      cs_rise   = 1'b0;
   end

   // read path follows the written code so readback needs no extra turn
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic c);
   begin
      @(negedge core_clk);
      req     = '{wr: 1'b1, addr: a, data: d};
      rd_addr = a;
      cs_rise = c;
      @(negedge core_clk);
      req.wr  = 1'b0;
      cs_rise = 1'b0;
   end
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
   begin
      @(negedge core_clk);
      rd_addr = a;
      repeat (3) @(negedge core_clk);
      v = rdata;
   end
   endtask : rd

   task automatic bump;
   begin
      @(negedge core_clk);
      byte_done = 1'b1;
      @(negedge core_clk);
      byte_done = 1'b0;
   end
   endtask : bump
endmodule : lmic_host

`default_nettype wire

// ==== tb/lmic_top_tb.sv ====
// lmic_top_tb: register, pointer, pwm and plane sequencer tests.
// assumes lmic_host drives the register port off the falling edge.
`timescale 1ns/100ps
`default_nettype none

module lmic_top_tb;
   localparam int SEC = 100;
   logic                    core_clk;
   logic                    resetn;
   lmic_pkg::lmic_reg_req_t req;
   lmic_pkg::lmic_drive_t   drive;
   logic [7:0]              rd_addr, rdata, driver_sel, v;
   logic                    byte_done, cs_rise, plane_depth_select;
   logic [1:0]              cur_plane, digit_geometric;
   logic [1:0][1:0]         pix_code;
   logic [13:0]             disp_ptr;
   int                      miscompares, check_count, cyc;
   logic [7:0]  wa [8] = '{8'h02, 8'h03, 8'h04, 8'h08,
                           8'h09, 8'h0A, 8'h0D, 8'h05};
   logic [7:0]  wd [8] = '{8'h80, 8'hFF, 8'h01, 8'hFF,
                           8'hFF, 8'hFF, 8'h8C, 8'hAA};
   logic [7:0]  we [8] = '{8'h80, 8'hFF, 8'h01, 8'hFF,
                           8'hFF, 8'h3F, 8'h80, 8'h00};
   logic [7:0]  pc [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
   logic [15:0] pe [4] = '{16'h0002, 16'h0002, 16'h0080, 16'h00FF};
   logic [15:0] de [4] = '{16'h0001, 16'h0001, 16'h0040, 16'h007F};
   logic [15:0] d1 [4] = '{16'h0000, 16'h0000, 16'h0020, 16'h003F};
   logic [15:0] np, nd, n1;
   logic        depth_fixed;

   lmic_top #(.SEC_CYC(SEC), .PWM_STEP_CYC(1)) u_dut (
      .core_clk(core_clk), .resetn(resetn), .req(req),
      .rd_addr(rd_addr), .byte_done(byte_done), .cs_rise(cs_rise),
      .digit_geometric(digit_geometric), .pix_code(pix_code),
      .drive(drive), .rdata(rdata), .cur_plane(cur_plane),
      .plane_depth_select(plane_depth_select), .disp_ptr(disp_ptr),
      .driver_sel(driver_sel));
   lmic_host u_host (.core_clk(core_clk), .rdata(rdata), .req(req),
      .rd_addr(rd_addr), .byte_done(byte_done), .cs_rise(cs_rise));
   // variant without four-step intensity shares the stimulus
   lmic_top #(.FOUR_STEP(1'b0), .SEC_CYC(SEC), .PWM_STEP_CYC(1))
      u_dut_fixed (
      .core_clk(core_clk), .resetn(resetn), .req(req),
      .rd_addr(rd_addr), .byte_done(byte_done), .cs_rise(cs_rise),
      .digit_geometric(digit_geometric), .pix_code(pix_code),
      .drive(), .rdata(), .cur_plane(),
      .plane_depth_select(depth_fixed), .disp_ptr(), .driver_sel());

   initial core_clk = 1'b0;
   always #4 core_clk = ~core_clk;

   // ------------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
   begin
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %0h expected %0h",
                  $time, got, exp);
      end
   end
   endtask : chk

   task automatic stop_test;
   begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask : stop_test

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // counts over any 256 cycles of a 256-cycle period give the duty
   task automatic meas;
   begin
      np = '0;
      nd = '0;
      n1 = '0;
      repeat (300) @(negedge core_clk);
      repeat (256)
      begin
         @(negedge core_clk);
         np += 16'(drive.panel_on);
         nd += 16'(drive.digit_on[0]);
         n1 += 16'(drive.digit_on[1]);
      end
   end
   endtask : meas

   // a 12-frame pattern spans twelve pwm periods, so any window of that
   // length sees every frame for exactly 256 cycles
   task automatic pix_meas(input logic [1:0] code);
   begin
      pix_code = {code, code};
      np = '0;
      nd = '0;
      repeat (12 * 256)
      begin
         @(negedge core_clk);
         np += 16'(drive.pixel_on[0]);
         nd += 16'(drive.pixel_on[1]);
      end
   end
   endtask : pix_meas

   // samples mid-interval so the exact advance cycle does not matter
   task automatic auto_run(input logic [7:0] code, input int per,
                           input int n, input int planes);
   begin
      u_host.wr(8'h0B, code, 1'b1);
      repeat (per / 2) @(negedge core_clk);
      for (int i = 0; i < n; i++)
      begin
         chk(16'(cur_plane), 16'(i % planes));
         repeat (per) @(negedge core_clk);
      end
   end
   endtask : auto_run

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         stop_test();
      end
   end

   initial
   begin
      resetn          = 1'b0;
      digit_geometric = 2'b00;
      pix_code        = '0;
      repeat (10) @(negedge core_clk);
      resetn = 1'b1;
      foreach (wa[i])
      begin
         u_host.rd(wa[i], v);
         chk(16'(v), 16'h0000);
      end
      foreach (wa[i])
      begin
         u_host.wr(wa[i], wd[i], 1'b0);
         u_host.rd(wa[i], v);
         chk(16'(v), 16'(we[i]));
      end
      chk(16'(driver_sel), 16'h00FF);
      chk(16'(disp_ptr), 16'h3FFF);
      u_host.bump();
      chk(16'(disp_ptr), 16'h0000);
      $display("test done: registers and pointer");
      u_host.wr(8'h0D, 8'h00, 1'b0);
      u_host.wr(8'h0B, 8'h03, 1'b0);
      chk(16'(cur_plane), 16'h0000);
      u_host.wr(8'h0B, 8'h03, 1'b1);
      chk(16'(cur_plane), 16'h0003);
      u_host.wr(8'h0D, 8'h80, 1'b0);
      chk(16'(plane_depth_select), 16'h0001);
      chk(16'(depth_fixed), 16'h0000);
      u_host.wr(8'h0B, 8'h02, 1'b1);
      chk(16'(cur_plane), 16'h0000);
      u_host.wr(8'h0B, 8'h03, 1'b1);
      chk(16'(cur_plane), 16'h0001);
      u_host.wr(8'h0B, 8'hC1, 1'b0);
      repeat (SEC + SEC / 2) @(negedge core_clk);
      chk(16'(cur_plane), 16'h0001);
      $display("test done: manual planes");
      u_host.wr(8'h03, 8'h80, 1'b0);
      u_host.wr(8'h04, 8'h40, 1'b0);
      foreach (pc[i])
      begin
         u_host.wr(8'h02, pc[i], 1'b0);
         meas();
         chk(np, pe[i]);
         chk(nd, de[i]);
         chk(n1, d1[i]);
      end
      $display("test done: brightness");
      u_host.wr(8'h0D, 8'h00, 1'b0);
      auto_run(8'h42, 2 * SEC, 5, 4);
      u_host.wr(8'h0D, 8'h80, 1'b0);
      auto_run(8'hC4, SEC / 4, 3, 2);
      auto_run(8'hC0, SEC / 2, 3, 1);
      $display("test done: auto planes");
      // digit 0 arithmetic, digit 1 geometric, same code on both
      digit_geometric = 2'b10;
      pix_meas(2'h2);
      chk(np, 16'h0800);
      chk(nd, 16'h0600);
      pix_meas(2'h1);
      chk(np, 16'h0400);
      chk(nd, 16'h0300);
      u_host.wr(8'h0D, 8'h00, 1'b0);
      pix_meas(2'h1);
      chk(np, 16'h0C00);
      chk(nd, 16'h0C00);
      $display("test done: pixel levels");
      stop_test();
   end
endmodule : lmic_top_tb

`default_nettype wire
